/* File: rtl/tcu_pkg.sv */
// Purpose: constants and carriers for the two-group timer unit
// Assumes: apb with 8-bit byte address and 32-bit data
// Notes:   timers 0..2 form the first group, 3..4 the second
package tcu_pkg;
    localparam int NT        = 5;       // timers in the unit
    localparam int TW        = 16;      // timer width
    localparam int PIN_W     = 11;      // in[4:0], dir[4:0], cap
    localparam int G1_DIV    = 4;       // first group base rate
    localparam int G2_DIV    = 2;       // second group base rate
    // timer index
    localparam int T_AUXL    = 0;
    localparam int T_CORE    = 1;
    localparam int T_AUXH    = 2;
    localparam int T_SAUX    = 3;
    localparam int T_SCORE   = 4;
    // register map
    localparam logic [7:0] OFS_CFG  = 8'h00; // five words, one per timer
    localparam logic [7:0] OFS_CNT  = 8'h20; // five words, timer values
    localparam logic [7:0] OFS_CAPR = 8'h34; // capture_reload_reg
    localparam logic [7:0] OFS_STAT = 8'h38; // toggle latches
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    // config field positions
    localparam int CF_MODE   = 0;       // 2 bits, first group mode
    localparam int CF_FN     = 2;       // 2 bits, aux function/sources
    localparam int CF_RUN    = 4;
    localparam int CF_DIR    = 5;       // 1 = count down
    localparam int CF_DPIN   = 6;       // direction pin inverts dir
    localparam int CF_PRE    = 7;       // 3 bits, divide by 2**n
    localparam int CF_CHAIN  = 10;      // clock from toggle latch
    localparam int CF_EXT    = 11;      // second group external clock
    localparam int CF_OUTEN  = 12;      // toggle latch to pin
    localparam int CF_TRG    = 13;      // 2 bits, reload trigger
    localparam int CF_CLR    = 15;      // clear after capture
    typedef enum logic [1:0] {
        TCU_M_TIMER = 2'b00,
        TCU_M_GATED = 2'b01,
        TCU_M_COUNT = 2'b10,
        TCU_M_INCR  = 2'b11
    } tcu_mode_t;
    typedef enum logic [1:0] {
        TCU_F_NORM = 2'b00,
        TCU_F_CAPT = 2'b01,
        TCU_F_RELD = 2'b10,
        TCU_F_RSVD = 2'b11
    } tcu_fn_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tcu_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tcu_apb_rsp_t;
    typedef struct packed {
        logic       cap;                // capture_input_pin
        logic [4:0] dir;                // timer_direction_pin per timer
        logic [4:0] inp;                // timer_input_pin per timer
    } tcu_pin_in_t;
    typedef struct packed {
        logic core_tog;                 // core_toggle_out_pin
        logic second_tog;               // second_toggle_out_pin
        logic second_wrap;              // wrap pulse for compare timers
    } tcu_pin_out_t;
endpackage

/* File: rtl/tcu_timer_unit.sv */
// Purpose: five 16-bit timers in two groups behind an apb slave
// Assumes: pins are asynchronous and pass two flops before use
// Notes on behaviour
// - five 16-bit timers, groups of three and two
// - chaining only inside one group
// - first group: timer, gated, counter, incremental
// - timer mode counts prescaled system clock
// - counter mode counts input pin events
// - gated mode counts while gate pin high
// - first group counts at most every 4 clocks
// - direction by software or direction pin
// - incremental mode decodes quadrature A and B
// - core wrap toggles latch; latch drives pin, aux
// - aux as capture or reload stops counting
// - capture copies core into aux on pin
// - reload core from aux on pin or latch edge
// - opposite latch edges reload: hardware pwm
// - second group: two timers, register, every 2
// - second group: prescaled or external clock
// - second group direction by software or pin
// - second core wrap toggles latch; clocks aux, pin
// - second core wrap exported and reloads from register
// - capture pin copies second aux, optional clear
// - capture also on core input or direction edges
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/10ps
module tcu_timer_unit (
    input  wire logic                  ref_clk_i, // 100 MHz clock
    input  wire logic                  reset_i,   // sync, active high
    input  wire tcu_pkg::tcu_apb_req_t apb_i,     // apb request
    output tcu_pkg::tcu_apb_rsp_t      apb_o,     // apb answer
    input  wire tcu_pkg::tcu_pin_in_t  pins_i,    // async pins
    output tcu_pkg::tcu_pin_out_t      pins_o     // registered outputs
);
    import tcu_pkg::*;

    logic [15:0]      cfg_q [NT];
    logic [TW-1:0]    cnt_q [NT];
    logic [TW-1:0]    cnt_d [NT];
    logic [TW-1:0]    capr_q;
    logic [TW-1:0]    capr_d;
    logic [PIN_W-1:0] s1_q, s2_q, s3_q;
    logic [1:0]       div1_q;
    logic             div2_q;
    logic [7:0]       pre1_q, pre2_q;
    logic [NT-1:0]    pend_q, pend_d, pdn_q, pdn_d;
    logic [NT-1:0]    en, dn, wrap;
    logic             lat1_q, lat2_q, tog1_q, tog2_q;
    logic [31:0]      rdata_q;
    logic             err_q;
    tcu_pin_out_t     out_q;

    // prescaler tap hit: low n bits of the prescale counter all ones
    function automatic logic pre_hit(input logic [7:0] c,
                                     input logic [2:0] n);
        logic [7:0] m;
        m = ~(8'hff << n);
        pre_hit = ((c & m) == m) || (n == 3'd0);
    endfunction

    // hit flag for a word address inside a five-word bank
    function automatic logic bank_hit(input logic [7:0] a,
                                      input logic [7:0] base);
        bank_hit = (a[7:5] == base[7:5]) && (a[4:2] < 3'd5)
                   && (a[1:0] == 2'b00);
    endfunction

    // pin synchroniser; stage one feeds stage two only
    always_ff @(posedge ref_clk_i) begin
        s1_q <= {pins_i.cap, pins_i.dir, pins_i.inp};
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    wire [PIN_W-1:0] lvl  = s2_q;
    wire [PIN_W-1:0] edg  = s2_q ^ s3_q;
    wire [PIN_W-1:0] rise = s2_q & ~s3_q;

    // base rates; a single clock with enable pulses, no derived clocks
    wire tick1 = (div1_q == 2'(G1_DIV - 1));
    wire tick2 = div2_q;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            div1_q <= 2'h0;
            div2_q <= 1'b0;
            pre1_q <= 8'h00;
            pre2_q <= 8'h00;
        end else begin
            div1_q <= div1_q + 2'h1;
            div2_q <= ~div2_q;
            if (tick1) pre1_q <= pre1_q + 8'h01;
            if (tick2) pre2_q <= pre2_q + 8'h01;
        end
    end

    // apb decode; writes land at the access edge
    wire       acc  = apb_i.psel & apb_i.penable;
    wire       wr   = acc & apb_i.pwrite;
    wire [7:0] ad   = apb_i.paddr;
    wire [2:0] idx  = ad[4:2];
    wire       hcfg = bank_hit(ad, OFS_CFG);
    wire       hcnt = bank_hit(ad, OFS_CNT);
    wire       hcap = (ad == OFS_CAPR);
    wire       hst  = (ad == OFS_STAT);
    wire       hok  = hcfg | hcnt | hcap | hst;

    // per-timer count enable, direction and wrap
    always_comb begin
        logic        g1;
        logic        tk;
        logic        tp;
        logic [15:0] c;
        g1 = 1'b0;
        tk = 1'b0;
        tp = 1'b0;
        c  = 16'h0000;
        for (int i = 0; i < NT; i++) begin
            c  = cfg_q[i];
            g1 = (i < 3);
            tk = g1 ? tick1 : tick2;
            tp = tk && pre_hit(g1 ? pre1_q : pre2_q,
                               c[CF_PRE+:3]);
            dn[i] = c[CF_DIR] ^ (c[CF_DPIN] & lvl[5+i]);
            if (g1) begin
                case (tcu_mode_t'(c[CF_MODE+:2]))
                    TCU_M_TIMER: en[i] = tp;
                    TCU_M_GATED: en[i] = tp & lvl[i];
                    TCU_M_COUNT: en[i] = pend_q[i] & tk;
                    TCU_M_INCR: begin
                        en[i] = pend_q[i] & tk;
                        dn[i] = pdn_q[i] ^ c[CF_DIR];
                    end
                    default: en[i] = 1'b0;
                endcase
            end else begin
                en[i] = c[CF_EXT] ? (pend_q[i] & tk) : tp;
            end
            // aux timers of each group may run from their latch
            if (c[CF_CHAIN] && (i == T_AUXL || i == T_AUXH))
                en[i] = tog1_q;
            if (c[CF_CHAIN] && i == T_SAUX)
                en[i] = tog2_q;
            // a first-group aux used as capture or reload is stopped
            if ((i == T_AUXL || i == T_AUXH)
                && c[CF_FN+:2] != TCU_F_NORM)
                en[i] = 1'b0;
            en[i]   = en[i] & c[CF_RUN];
            wrap[i] = en[i] & (dn[i] ? (cnt_q[i] == 16'h0000)
                                     : (cnt_q[i] == 16'hffff));
        end
    end

    // event pending flags; an edge arriving on the consuming tick wins
    always_comb begin
        logic qa;
        logic qb;
        qa = 1'b0;
        qb = 1'b0;
        for (int i = 0; i < NT; i++) begin
            qa = edg[i];
            qb = edg[5+i];
            pend_d[i] = pend_q[i] & ~((i < 3) ? tick1 : tick2);
            pdn_d[i]  = pdn_q[i];
            if ((i < 3) && cfg_q[i][CF_MODE+:2] == TCU_M_INCR) begin
                if (qa | qb) begin
                    pend_d[i] = 1'b1;
                    // a leading b counts up, b leading a counts down
                    pdn_d[i]  = qa ? ~(lvl[i] ^ lvl[5+i])
                                   : (lvl[i] ^ lvl[5+i]);
                end
            end else if (rise[i]) begin
                pend_d[i] = 1'b1;
            end
        end
    end

    // reload triggers of the core timer from each aux timer
    function automatic logic rl_trig(input logic [15:0] c,
                                     input logic pin_rise,
                                     input logic w,
                                     input logic lat);
        case (c[CF_TRG+:2])
            2'b00:   rl_trig = pin_rise;
            2'b01:   rl_trig = w & ~lat;   // latch rising
            2'b10:   rl_trig = w & lat;    // latch falling
            default: rl_trig = w;
        endcase
    endfunction

    wire [1:0] fn_l = cfg_q[T_AUXL][CF_FN+:2];
    wire [1:0] fn_h = cfg_q[T_AUXH][CF_FN+:2];
    wire rl_l = (fn_l == TCU_F_RELD)
                && rl_trig(cfg_q[T_AUXL], rise[T_AUXL],
                           wrap[T_CORE], lat1_q);
    wire rl_h = (fn_h == TCU_F_RELD)
                && rl_trig(cfg_q[T_AUXH], rise[T_AUXH],
                           wrap[T_CORE], lat1_q);
    wire cp_l = (fn_l == TCU_F_CAPT) && rise[T_AUXL];
    wire cp_h = (fn_h == TCU_F_CAPT) && rise[T_AUXH];
    wire [15:0] sc  = cfg_q[T_SAUX];
    wire cap2 = (sc[CF_FN] & rise[10])
                | (sc[CF_FN+1] & (edg[T_CORE] | edg[5+T_CORE]));
    wire rl2  = wrap[T_SCORE] & cfg_q[T_SCORE][CF_FN];

    // next timer values; software writes take priority
    always_comb begin
        for (int i = 0; i < NT; i++) begin
            cnt_d[i] = cnt_q[i];
            if (en[i])
                cnt_d[i] = dn[i] ? cnt_q[i] - 16'h0001
                                 : cnt_q[i] + 16'h0001;
        end
        // with both aux timers reloading on opposite edges the core
        // alternates two periods and the latch forms a pwm wave
        if (rl_l) cnt_d[T_CORE] = cnt_q[T_AUXL];
        if (rl_h) cnt_d[T_CORE] = cnt_q[T_AUXH];
        if (cp_l) cnt_d[T_AUXL] = cnt_q[T_CORE];
        if (cp_h) cnt_d[T_AUXH] = cnt_q[T_CORE];
        if (rl2)  cnt_d[T_SCORE] = capr_q;
        if (cap2 && sc[CF_CLR]) cnt_d[T_SAUX] = CNT_RST;
        if (wr && hcnt && idx < 3'd5)
            cnt_d[idx] = apb_i.pwdata[TW-1:0];
    end

    always_comb begin
        capr_d = capr_q;
        if (cap2) capr_d = cnt_q[T_SAUX];
        if (wr && hcap) capr_d = apb_i.pwdata[TW-1:0];
    end

    // timer state and registers
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < NT; i++) begin
                cfg_q[i] <= CFG_RST;
                cnt_q[i] <= CNT_RST;
            end
            capr_q <= CNT_RST;
            pend_q <= '0;
            pdn_q  <= '0;
        end else begin
            for (int i = 0; i < NT; i++)
                cnt_q[i] <= cnt_d[i];
            if (wr && hcfg)
                cfg_q[idx] <= apb_i.pwdata[15:0];
            capr_q <= capr_d;
            pend_q <= pend_d;
            pdn_q  <= pdn_d;
        end
    end

    // toggle latches; the chained aux sees the toggle one clock later
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            lat1_q <= 1'b0;
            lat2_q <= 1'b0;
            tog1_q <= 1'b0;
            tog2_q <= 1'b0;
            out_q  <= '0;
        end else begin
            lat1_q <= lat1_q ^ wrap[T_CORE];
            lat2_q <= lat2_q ^ wrap[T_SCORE];
            tog1_q <= wrap[T_CORE];
            tog2_q <= wrap[T_SCORE];
            out_q.core_tog    <= cfg_q[T_CORE][CF_OUTEN]
                                 & (lat1_q ^ wrap[T_CORE]);
            out_q.second_tog  <= cfg_q[T_SCORE][CF_OUTEN]
                                 & (lat2_q ^ wrap[T_SCORE]);
            out_q.second_wrap <= wrap[T_SCORE];
        end
    end

    // read data is sampled in the setup cycle so it comes from flops
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else if (apb_i.psel && !apb_i.penable) begin
            err_q   <= ~hok;
            rdata_q <= 32'h0000_0000;
            if (hcfg) rdata_q <= {16'h0000, cfg_q[idx]};
            if (hcnt) rdata_q <= {16'h0000, cnt_q[idx]};
            if (hcap) rdata_q <= {16'h0000, capr_q};
            if (hst)  rdata_q <= {30'h0, lat2_q, lat1_q};
        end
    end

    assign apb_o.prdata  = rdata_q;
    assign apb_o.pready  = 1'b1;
    assign apb_o.pslverr = err_q & acc;
    assign pins_o        = out_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    wire wr_cnt1 = wr & hcnt & (idx == 3'(T_CORE));
    wire wr_cnt0 = wr & hcnt & (idx == 3'(T_AUXL));
    wire wr_cnt3 = wr & hcnt & (idx == 3'(T_SAUX));

    property p_g1_gap;
        tick1 |=> !tick1 [*3];
    endproperty
    a_g1_gap: assert property (p_g1_gap)
        else $error("first group tick closer than four clocks");

    property p_g1_rate;
        en[T_CORE] |-> tick1 || tog1_q;
    endproperty
    a_g1_rate: assert property (p_g1_rate)
        else $error("core counted off the base tick");

    property p_g2_gap;
        tick2 |=> !tick2 ##1 tick2;
    endproperty
    a_g2_gap: assert property (p_g2_gap)
        else $error("second group tick not every two clocks");

    property p_core_latch;
        wrap[T_CORE] |=> lat1_q != $past(lat1_q);
    endproperty
    a_core_latch: assert property (p_core_latch)
        else $error("core latch did not toggle on wrap");

    sequence s_sc_wrap;
        wrap[T_SCORE] ##1 out_q.second_wrap;
    endsequence
    property p_sc_latch;
        wrap[T_SCORE] |-> s_sc_wrap ##0 (lat2_q != $past(lat2_q));
    endproperty
    a_sc_latch: assert property (p_sc_latch)
        else $error("second latch or wrap pulse missing");

    property p_aux_stop;
        (fn_l != TCU_F_NORM && !cp_l && !wr_cnt0)
            |=> $stable(cnt_q[T_AUXL]);
    endproperty
    a_aux_stop: assert property (p_aux_stop)
        else $error("aux timer counted while capture or reload");

    property p_capture;
        (cp_l && !wr_cnt0) |=> cnt_q[T_AUXL] == $past(cnt_q[T_CORE]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("core value not captured into aux");

    property p_capr;
        (cap2 && !(wr && hcap)) |=> capr_q == $past(cnt_q[T_SAUX]);
    endproperty
    a_capr: assert property (p_capr)
        else $error("capture register missed second aux value");

    property p_wrap_up;
        (en[T_CORE] && !dn[T_CORE] && cnt_q[T_CORE] == 16'hffff
         && !rl_l && !rl_h && !wr_cnt1) |=> cnt_q[T_CORE] == 16'h0000;
    endproperty
    a_wrap_up: assert property (p_wrap_up)
        else $error("core did not wrap to zero");

    property p_gate;
        (cfg_q[T_CORE][CF_MODE+:2] == TCU_M_GATED && !lvl[T_CORE]
         && !cfg_q[T_CORE][CF_CHAIN]) |-> !en[T_CORE];
    endproperty
    a_gate: assert property (p_gate)
        else $error("gated core counted with gate low");

    // aux high has reload priority, so its value must land in the core
    property p_reload;
        (rl_h && !wr_cnt1) |=> cnt_q[T_CORE] == $past(cnt_q[T_AUXH]);
    endproperty
    a_reload: assert property (p_reload)
        else $error("core not reloaded from aux high");

    property p_g2_rate;
        en[T_SCORE] |-> tick2;
    endproperty
    a_g2_rate: assert property (p_g2_rate)
        else $error("second core counted off the base tick");

    property p_capr_clear;
        (cap2 && sc[CF_CLR] && !wr_cnt3) |=> cnt_q[T_SAUX] == 16'h0000;
    endproperty
    a_capr_clear: assert property (p_capr_clear)
        else $error("second aux not cleared after capture");
endmodule

/* File: test/tcu_pin_model.sv */
// Purpose: pin-side model, gate, event, direction and sensor lines
// Assumes: levels change by non-blocking update after a rising edge
// Notes:   pulses are seven clocks high and low, wider than a tick
`timescale 1ns/10ps
module tcu_pin_model
    import tcu_pkg::*;
(
    input  wire logic clk_i,  // bench clock
    output tcu_pin_in_t pins_o // levels toward the unit
);
    int ph = 0;
    initial pins_o = '0;
    // hold a level on input pin idx, 5 is the capture pin
    task automatic set_in(input int idx, input logic v);
        @(posedge clk_i);
        if (idx == 5) pins_o.cap <= v;
        else pins_o.inp[idx] <= v;
    endtask
    task automatic set_dir(input int idx, input logic v);
        @(posedge clk_i);
        pins_o.dir[idx] <= v;
    endtask
    // one event, slow enough that the first group never drops it
    task automatic pulse(input int idx);
        set_in(idx, 1'b1);
        repeat (6) @(posedge clk_i);
        set_in(idx, 1'b0);
        repeat (6) @(posedge clk_i);
    endtask
    // quadrature on core lines: a is the input pin, b the direction pin
    task automatic quad(input int steps, input bit up);
        for (int s = 0; s < steps; s++) begin
            ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
            @(posedge clk_i);
            pins_o.inp[1] <= (ph == 1 || ph == 2);
            pins_o.dir[1] <= (ph >= 2);
            repeat (8) @(posedge clk_i);
        end
    endtask
endmodule

/* File: test/test_dual_group_timer_counter_unit.sv */
// Purpose: self-checking bench for the two-group timer unit
// Assumes: apb answers with no wait states, pins pass two sync flops
// Notes:   rate checks allow a few ticks for apb and sync latency
`timescale 1ns/10ps
module test_dual_group_timer_counter_unit;
    import tcu_pkg::*;
    logic         ref_clk_i = 1'b0;
    logic         reset_i   = 1'b1;
    tcu_apb_req_t req       = '0;
    tcu_apb_rsp_t rsp;
    tcu_pin_in_t  pins;
    tcu_pin_out_t pout;
    logic [31:0]  rdat;
    logic         rerr;
    int           n_errors = 0;
    int           comparisons = 0;
    int           seed = 99;
    int           k;
    logic [15:0]  v;
    always #5 ref_clk_i = ~ref_clk_i;
    tcu_timer_unit dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .apb_i(req), .apb_o(rsp), .pins_i(pins), .pins_o(pout));
    tcu_pin_model pin_u (.clk_i(ref_clk_i), .pins_o(pins));
    task automatic end_of_test();
        $display("checks %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input bit ok, input string m);
        comparisons++;
        if (!ok) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
        @(posedge ref_clk_i);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            chk(0, "apb answer missing");
            end_of_test();
        end else begin
            rdat = rsp.prdata;
            rerr = rsp.pslverr;
            req.psel    <= 1'b0;
            req.penable <= 1'b0;
        end
    endtask
    function automatic logic [7:0] ca(input int i);
        return OFS_CNT + 8'(4 * i);
    endfunction
    function automatic logic [7:0] fa(input int i);
        return OFS_CFG + 8'(4 * i);
    endfunction
    task automatic rd_eq(input logic [7:0] a, input logic [15:0] e,
                         input string m);
        apb(a, 1'b0, 32'h0);
        chk(rdat[15:0] === e && rerr === 1'b0, m);
    endtask
    task automatic rd_in(input logic [7:0] a, input int lo, input int hi,
                         input string m);
        apb(a, 1'b0, 32'h0);
        chk(rdat[15:0] >= lo && rdat[15:0] <= hi, m);
    endtask
    task automatic clr();
        for (int i = 0; i < NT; i++) apb(fa(i), 1'b1, 32'h0);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic done(input string t);
        $display("test %s done", t);
    endtask
    // expected tick count from the base rate and prescale exponent
    function automatic int ticks(input int clks, input int dv, input int p);
        return clks / (dv << p);
    endfunction
    initial begin
        wait_n(6);
        reset_i <= 1'b0;
        for (int i = 0; i < NT; i++) begin
            rd_eq(fa(i), CFG_RST, "cfg reset");
            rd_eq(ca(i), CNT_RST, "count reset");
        end
        rd_eq(OFS_STAT, 16'h0000, "status reset");
        apb(8'h3c, 1'b1, 32'h1);
        apb(8'h3c, 1'b0, 32'h0);
        chk(rerr === 1'b1 && rdat === 32'h0, "unmapped read");
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            apb(ca(T_AUXL), 1'b1, {16'h0, v});
            rd_eq(ca(T_AUXL), v, "count load");
        end
        done("registers");
        // rates: first group every 4 clocks, second every 2
        for (int p = 0; p < 2; p++) begin
            apb(fa(T_CORE), 1'b1, 32'h10 | (p << CF_PRE));
            apb(ca(T_CORE), 1'b1, 32'h0);
            wait_n(400);
            k = ticks(400, G1_DIV, p);
            rd_in(ca(T_CORE), k - 1, k + 3, "core rate");
        end
        apb(fa(T_SCORE), 1'b1, 32'h10);
        apb(ca(T_SCORE), 1'b1, 32'h0);
        wait_n(400);
        k = ticks(400, G2_DIV, 0);
        rd_in(ca(T_SCORE), k - 1, k + 4, "second rate");
        clr();
        done("rates");
        apb(fa(T_CORE), 1'b1, 32'h1010);
        apb(ca(T_CORE), 1'b1, 32'hfffe);
        wait_n(20);
        chk(pout.core_tog === 1'b1, "core toggle pin");
        rd_eq(OFS_STAT, 16'h0001, "latch after overflow");
        rd_in(ca(T_CORE), 1, 6, "wrap to zero");
        apb(fa(T_CORE), 1'b1, 32'h1030);
        apb(ca(T_CORE), 1'b1, 32'h0001);
        wait_n(20);
        rd_eq(OFS_STAT, 16'h0000, "latch after underflow");
        rd_in(ca(T_CORE), 16'hfff8, 16'hffff, "wrap to ones");
        done("wrap");
        // second core reloads from the capture register on each wrap
        apb(OFS_CAPR, 1'b1, 32'hfff0);
        apb(fa(T_SCORE), 1'b1, 32'h1014);
        apb(ca(T_SCORE), 1'b1, 32'hfffe);
        k = 0;
        for (int c = 0; c < 60; c++) begin
            @(posedge ref_clk_i);
            if (pout.second_wrap === 1'b1) k++;
        end
        chk(k == 2, "second wrap pulses");
        rd_in(ca(T_SCORE), 16'hfff0, 16'hffff, "reload");
        apb(OFS_STAT, 1'b0, 32'h0);
        chk(rdat[1] === pout.second_tog, "second latch");
        clr();
        done("second wrap");
        apb(fa(T_CORE), 1'b1, 32'h12);
        apb(ca(T_CORE), 1'b1, 32'h0);
        k = ($random(seed) & 7) + 1;
        for (int i = 0; i < k; i++) pin_u.pulse(1);
        wait_n(10);
        rd_eq(ca(T_CORE), 16'(k), "event count");
        apb(fa(T_CORE), 1'b1, 32'h11);
        apb(ca(T_CORE), 1'b1, 32'h0);
        pin_u.set_in(1, 1'b1);
        wait_n(200);
        pin_u.set_in(1, 1'b0);
        wait_n(100);
        rd_in(ca(T_CORE), 48, 52, "gated count");
        pin_u.set_dir(1, 1'b1);
        apb(fa(T_CORE), 1'b1, 32'h50);
        apb(ca(T_CORE), 1'b1, 32'h1000);
        wait_n(400);
        rd_in(ca(T_CORE), 16'h0f9a, 16'h0f9e, "pin direction");
        pin_u.set_dir(1, 1'b0);
        apb(fa(T_CORE), 1'b1, 32'h13);
        apb(ca(T_CORE), 1'b1, 32'h0);
        pin_u.quad(8, 1'b1);
        rd_eq(ca(T_CORE), 16'h0008, "quadrature up");
        pin_u.quad(4, 1'b0);
        rd_eq(ca(T_CORE), 16'h0004, "quadrature down");
        clr();
        done("pins");
        apb(ca(T_CORE), 1'b1, 32'h1234);
        apb(fa(T_AUXL), 1'b1, 32'h14);
        pin_u.pulse(0);
        wait_n(100);
        rd_eq(ca(T_AUXL), 16'h1234, "capture, aux held");
        apb(fa(T_AUXH), 1'b1, 32'h8);
        apb(ca(T_AUXH), 1'b1, 32'h5555);
        pin_u.pulse(2);
        rd_eq(ca(T_CORE), 16'h5555, "reload from pin");
        clr();
        apb(fa(T_SAUX), 1'b1, 32'h8004);
        apb(ca(T_SAUX), 1'b1, 32'h0abc);
        pin_u.pulse(5);
        rd_eq(OFS_CAPR, 16'h0abc, "capture pin");
        rd_eq(ca(T_SAUX), 16'h0000, "clear on capture");
        apb(fa(T_SAUX), 1'b1, 32'h8);
        apb(ca(T_SAUX), 1'b1, 32'h0def);
        pin_u.pulse(1);
        rd_eq(OFS_CAPR, 16'h0def, "capture on core pin");
        done("capture");
        // pwm: 16 ticks high from aux low, 8 ticks low from aux high
        clr();
        apb(ca(T_AUXL), 1'b1, 32'hfff0);
        apb(ca(T_AUXH), 1'b1, 32'hfff8);
        apb(fa(T_AUXL), 1'b1, 32'h2008);
        apb(fa(T_AUXH), 1'b1, 32'h4008);
        apb(ca(T_CORE), 1'b1, 32'hfff8);
        apb(fa(T_CORE), 1'b1, 32'h1010);
        wait_n(200);
        k = 0;
        // ten whole periods of 96 clocks, 64 of them high each
        for (int c = 0; c < 960; c++) begin
            @(posedge ref_clk_i);
            if (pout.core_tog === 1'b1) k++;
        end
        chk(k >= 636 && k <= 644, "pwm high time");
        // aux high chained to core wraps; aux low reloads on both edges
        clr();
        apb(ca(T_AUXH), 1'b1, 32'h0);
        apb(fa(T_AUXL), 1'b1, 32'h6008);
        apb(fa(T_AUXH), 1'b1, 32'h0410);
        apb(ca(T_CORE), 1'b1, 32'hfff0);
        apb(fa(T_CORE), 1'b1, 32'h10);
        wait_n(640);
        rd_in(ca(T_AUXH), 9, 11, "chained aux");
        // second core on external edges, counting down by its pin
        clr();
        pin_u.set_dir(4, 1'b1);
        apb(ca(T_SCORE), 1'b1, 32'h0100);
        apb(fa(T_SCORE), 1'b1, 32'h0850);
        k = ($random(seed) & 7) + 1;
        for (int i = 0; i < k; i++) pin_u.pulse(4);
        wait_n(10);
        rd_eq(ca(T_SCORE), 16'(256 - k), "ext down count");
        pin_u.set_dir(4, 1'b0);
        done("pwm and second clock");
        end_of_test();
    end
endmodule
